// File: src/adt_consts.vh
`ifndef ADT_CONSTS_VH
`define ADT_CONSTS_VH
// ==========================================================
// Register map
// ==========================================================
// Byte offsets of the software registers.
`define ADT_OFS_GAIN     8'h00
`define ADT_OFS_OFFSET   8'h04
`define ADT_OFS_ON       8'h08
`define ADT_OFS_DELTA    8'h0C
`define ADT_OFS_DEC      8'h10
`define ADT_OFS_SAMPLE   8'h14
`define ADT_OFS_STATUS   8'h18
`define ADT_OFS_ACTUAL   8'h1C
`define ADT_OFS_OFFTHR   8'h20
// ==========================================================
// Reset values and limits
// ==========================================================
// Gain is hundredths, so unity gain is 100.
`define ADT_GAIN_RST     16'h0064
`define ADT_GAIN_SCALE   16'h0064
`define ADT_GAIN_MAX     16'h03E8
`define ADT_OFFSET_MAX   16'h2710
`define ADT_THR_MAX      16'h4E20
`define ADT_SAMPLE_MAX   16'h03E8
`define ADT_DEC_MAX      2'h3
`endif

// File: src/adt_sat.v
`timescale 1ns/1ps
// ==========================================================
// Symmetric signed clamp
// ==========================================================
// Clamps a signed value into plus or minus a limit.
module adt_sat #(
	parameter W = 16                        // Data width.
) (
	input  wire signed [W-1:0] din,         // Value to clamp.
	input  wire        [W-1:0] lim,         // Positive magnitude limit.
	output wire signed [W-1:0] dout         // Clamped value.
);
	wire signed [W:0] lim_p = {1'b0, lim};  // Limit widened as positive.
	wire signed [W:0] lim_n = -lim_p;       // Negative limit.
	wire signed [W:0] dx    = {din[W-1], din}; // Sign extended input.

	// Out of range values snap to the nearest bound.
	assign dout = (dx > lim_p) ? lim_p[W-1:0] :
		(dx < lim_n) ? lim_n[W-1:0] : din;
endmodule // adt_sat

// File: src/adt_trigger.v
// Function
// - Sample is integer, 0..10 V maps 0..1000.
// - Actual equals sample times gain plus offset.
// - Off threshold equals On plus signed delta.
// - Negative delta: output high above On.
// - Negative delta: output low at/below Off.
// - Positive delta: high when On<=actual<Off.
// - Gain signed hundredths, magnitude at most ten.
// - On threshold signed, magnitude up to 20000.
// - Delta signed, magnitude up to 20000.
// - Decimals setting 0..3, display only.
// - Compares use raw integers, ignore decimals.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "adt_consts.vh"
module adt_trigger (
	input  wire        clk,                 // 200 MHz system clock.
	input  wire        resetn,              // Asynchronous reset, active low.
	input  wire [7:0]  addr,                // Register byte address.
	input  wire [31:0] wdata,               // Write data.
	input  wire        wr,                  // Write strobe.
	input  wire        rd,                  // Read strobe.
	input  wire [15:0] analog_sample_in,    // Analogue sample, same clock domain.
	input  wire        sample_valid,        // One-cycle pulse, sample is new.
	output reg  [31:0] rdata,               // Read data, one cycle after rd.
	output reg         trig_out             // Binary trigger output.
);
	// ==========================================================
	// Reset release
	// ==========================================================
	reg [1:0] rst_sync;                     // Reset release shifter.
	wire      rst_n = rst_sync[1];          // Synchronised reset.

	// Release is delayed two edges so all flops leave reset together.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	// ==========================================================
	// Settings
	// ==========================================================
	reg signed [15:0] gain;                 // Gain in hundredths.
	reg signed [15:0] offset;               // Zero offset.
	reg signed [15:0] on_thr;               // On threshold.
	reg signed [15:0] delta;                // Differential.
	reg        [1:0]  dec_places;           // Decimal places, display only.
	reg        [15:0] sample;               // Latched sample.

	wire signed [15:0] gain_c;              // Clamped gain write value.
	wire signed [15:0] offset_c;            // Clamped offset write value.
	wire signed [15:0] on_c;                // Clamped On write value.
	wire signed [15:0] delta_c;             // Clamped delta write value.

	// Clamps keep software writes inside the documented ranges.
	adt_sat #(.W(16)) u_sat_gain (
		.din  (wdata[15:0]),
		.lim  (`ADT_GAIN_MAX),
		.dout (gain_c)
	);
	adt_sat #(.W(16)) u_sat_ofs (
		.din  (wdata[15:0]),
		.lim  (`ADT_OFFSET_MAX),
		.dout (offset_c)
	);
	adt_sat #(.W(16)) u_sat_on (
		.din  (wdata[15:0]),
		.lim  (`ADT_THR_MAX),
		.dout (on_c)
	);
	adt_sat #(.W(16)) u_sat_dl (
		.din  (wdata[15:0]),
		.lim  (`ADT_THR_MAX),
		.dout (delta_c)
	);

	// Register writes.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain       <= `ADT_GAIN_RST;
			offset     <= 16'h0000;
			on_thr     <= 16'h0000;
			delta      <= 16'h0000;
			dec_places <= 2'h0;
		end else if (wr) begin
			case (addr)
				`ADT_OFS_GAIN:   gain <= gain_c;
				`ADT_OFS_OFFSET: offset <= offset_c;
				`ADT_OFS_ON:     on_thr <= on_c;
				`ADT_OFS_DELTA:  delta <= delta_c;
				// Decimals are stored for readback and never reach the compare.
				`ADT_OFS_DEC:    dec_places <= wdata[1:0];
				default: begin
				end
			endcase
		end
	end

	// Samples above full scale are clamped to 1000.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample <= 16'h0000;
		end else if (sample_valid) begin
			sample <= (analog_sample_in > `ADT_SAMPLE_MAX) ? `ADT_SAMPLE_MAX : analog_sample_in;
		end
	end

	// ==========================================================
	// Arithmetic
	// ==========================================================
	// Wide intermediates avoid overflow: 1000 * 1000 fits well in 32 bits.
	wire signed [31:0] prod   = $signed({16'h0000, sample}) * $signed({{16{gain[15]}}, gain});
	wire signed [31:0] scaled = prod / $signed({16'h0000, `ADT_GAIN_SCALE});
	wire signed [31:0] actual = scaled + $signed({{16{offset[15]}}, offset});
	wire signed [31:0] off_thr = $signed({{16{on_thr[15]}}, on_thr}) +
		$signed({{16{delta[15]}}, delta});
	wire signed [31:0] on_w   = $signed({{16{on_thr[15]}}, on_thr});
	reg                next_trig;           // Next output level.

	// Compare raw integers only; the decimal setting plays no part.
	always @* begin
		next_trig = trig_out;
		if (on_w >= off_thr) begin
			if (actual > on_w) begin
				next_trig = 1'b1;
			end else if (actual <= off_thr) begin
				next_trig = 1'b0;
			end else begin
				next_trig = trig_out;
			end
		end else begin
			if ((actual >= on_w) && (actual < off_thr)) begin
				next_trig = 1'b1;
			end else begin
				next_trig = 1'b0;
			end
		end
	end

	// Output is re-evaluated every cycle.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_out <= 1'b0;
		end else begin
			trig_out <= next_trig;
		end
	end

	// ==========================================================
	// Readback
	// ==========================================================
	// Unmapped addresses read zero; rdata holds only for the cycle after rd.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				`ADT_OFS_GAIN:   rdata <= {{16{gain[15]}}, gain};
				`ADT_OFS_OFFSET: rdata <= {{16{offset[15]}}, offset};
				`ADT_OFS_ON:     rdata <= {{16{on_thr[15]}}, on_thr};
				`ADT_OFS_DELTA:  rdata <= {{16{delta[15]}}, delta};
				`ADT_OFS_DEC:    rdata <= {30'h00000000, dec_places};
				`ADT_OFS_SAMPLE: rdata <= {16'h0000, sample};
				`ADT_OFS_STATUS: rdata <= {31'h00000000, trig_out};
				`ADT_OFS_ACTUAL: rdata <= actual;
				`ADT_OFS_OFFTHR: rdata <= off_thr;
				default:         rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule // adt_trigger

// File: bench/adt_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the trigger block
// ==========================================================
module adt_props (
	input wire        clk,              // Clock.
	input wire        resetn,           // Reset, active low.
	input wire [7:0]  addr,             // Register address.
	input wire [31:0] wdata,            // Write data.
	input wire        wr,               // Write strobe.
	input wire        rd,               // Read strobe.
	input wire [15:0] analog_sample_in, // Sample data.
	input wire        sample_valid,     // Sample strobe.
	input wire [31:0] rdata,            // Read data.
	input wire        trig_out          // Trigger output.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [31:0] on_m;                  // Mirror of the On threshold.
	logic [31:0] dl_m;                  // Mirror of the differential.
	// Mirrors assume in-range writes, so no clamp is modelled here.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			on_m <= 32'h0;
			dl_m <= 32'h0;
		end else if (wr && addr == 8'h08) begin
			on_m <= {{16{wdata[15]}}, wdata[15:0]};
		end else if (wr && addr == 8'h0C) begin
			dl_m <= {{16{wdata[15]}}, wdata[15:0]};
		end
	end
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
	unmapped_read_a: assert property (rd && addr > 8'h20 |=> rdata == 32'h0) else $error("unmapped read");
	status_read_a: assert property (rd && addr == 8'h18 |=> rdata == {31'h0, $past(trig_out)})
		else $error("status read");
	dec_read_a: assert property (wr && addr == 8'h10 ##2 rd && addr == 8'h10 |=> rdata == {30'h0, $past(wdata[1:0], 3)})
		else $error("decimals read");
	off_thr_a: assert property (rd && addr == 8'h20 |=> rdata == on_m + dl_m) else $error("off threshold");
	on_read_a: assert property (rd && addr == 8'h08 |=> rdata == on_m) else $error("on read");
	delta_read_a: assert property (rd && addr == 8'h0C |=> rdata == dl_m) else $error("delta read");
	trig_cause_a: assert property ($changed(trig_out) |-> $past(sample_valid, 2) || $past(wr, 2))
		else $error("trigger moved alone");
	cover property ($rose(trig_out));
	cover property ($fell(trig_out));
	cover property (rd && addr == 8'h18 ##1 rdata[0]);
endmodule // adt_props

// File: bench/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the trigger block
// ==========================================================
module tb;
	logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, sv = 1'b0; // Bench drives.
	logic [7:0] addr = 8'h0;                                        // Address.
	logic [31:0] wdata = 32'h0, rdata;                              // Bus data.
	logic [15:0] smp = 16'h0;                                       // Sample.
	logic trig;                                                     // Output.
	int fail_count = 0, compares = 0, cyc = 0;                      // Tallies.
	adt_trigger dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.analog_sample_in(smp), .sample_valid(sv), .rdata(rdata), .trig_out(trig));
	initial forever #2.5 clk = ~clk;
	// A hang ends the run as a failure.
	always @(posedge clk) if (++cyc > 5000) begin fail_count++; tally_and_finish(); end
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a; wdata <= d; wr <= 1'b1; @(posedge clk); wr <= 1'b0; @(posedge clk);
	endtask
	// Read data stand only in the cycle after the strobe, so it is looked at mid-cycle.
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		addr <= a; rd <= 1'b1; @(posedge clk); rd <= 1'b0; @(negedge clk); chk(rdata, e); @(posedge clk);
	endtask
	// The output settles two edges after the sample strobe.
	task automatic samp(input logic [15:0] v, input logic e);
		smp <= v; sv <= 1'b1; @(posedge clk); sv <= 1'b0; @(posedge clk); @(posedge clk);
		@(negedge clk); chk({31'h0, trig}, {31'h0, e}); @(posedge clk);
	endtask
	task automatic t_reset();
		rreg(8'h00, 32'h64); rreg(8'h04, 32'h0); rreg(8'h08, 32'h0);
		rreg(8'h0C, 32'h0); rreg(8'h10, 32'h0); rreg(8'h40, 32'h0); rreg(8'h18, 32'h0);
	endtask
	task automatic t_hyst();
		wreg(8'h08, 500); wreg(8'h0C, -100); wreg(8'h10, 32'h3); rreg(8'h10, 32'h3);
		rreg(8'h20, 32'h190);
		samp(600, 1'b1);
		samp(450, 1'b1);
		samp(500, 1'b1);
		samp(400, 1'b0);
		samp(450, 1'b0);
		samp(501, 1'b1);
		rreg(8'h18, 32'h1);
	endtask
	task automatic t_window();
		wreg(8'h00, 200); wreg(8'h04, -100); wreg(8'h08, 200); wreg(8'h0C, 300);
		samp(150, 1'b1);
		samp(300, 1'b0);
		samp(149, 1'b0);
		samp(250, 1'b1);
		wreg(8'h00, -100); wreg(8'h04, 500);
		samp(100, 1'b1);
		samp(2000, 1'b0);
		rreg(8'h14, 32'h3E8);
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_hyst();
		t_window();
		tally_and_finish();
	end
endmodule // tb
bind adt_trigger adt_props chk_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.analog_sample_in(analog_sample_in), .sample_valid(sample_valid), .rdata(rdata), .trig_out(trig_out));
